// file: core/protector_fet_fault_control.sv
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`include "fet_fault_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module protector_fet_fault_control #(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
    parameter int NUM_FAULTS  = 10
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [7:0]                 haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Analog comparator levels
    input  wire fet_fault_pkg::fault_vec_t  fault_cond_in,
    input  wire logic                       charge_state_in,
    input  wire logic                       discharge_state_in,
    input  wire logic                       selftest_bad_in,
    input  wire logic                       charge_override_in,
    input  wire logic                       discharge_override_in,
    // Drivers and self-test select
    output logic [3:0]                      selftest_sel,
    output logic                            charge_fet_drive,
    output logic                            discharge_fet_drive,
    output logic                            upper_charge_out
);
    import fet_fault_pkg::*;

    localparam int NUM_IN = NUM_FAULTS + 5;

    // Three-stage synchronisers; a change is accepted when stages two and three agree
    logic [NUM_IN-1:0] in_raw;
    logic [NUM_IN-1:0] s1_reg;
    logic [NUM_IN-1:0] s2_reg;
    logic [NUM_IN-1:0] s3_reg;
    logic [NUM_IN-1:0] clean_reg;
    assign in_raw = {discharge_override_in, charge_override_in, selftest_bad_in,
                     discharge_state_in, charge_state_in, fault_cond_in};
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            clean_reg <= '0;
        end else begin
            s1_reg <= in_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NUM_IN; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    clean_reg[i] <= s3_reg[i];
                end
            end
        end
    end
    fault_vec_t cond;
    logic       chg_cur;
    logic       dsg_cur;
    logic       st_bad;
    logic [1:0] ovr_raw;
    assign cond    = clean_reg[NUM_FAULTS-1:0];
    assign chg_cur = clean_reg[NUM_FAULTS];
    assign dsg_cur = clean_reg[NUM_FAULTS+1];
    assign st_bad  = clean_reg[NUM_FAULTS+2];
    assign ovr_raw = clean_reg[NUM_FAULTS+4:NUM_FAULTS+3];

    // Common sample tick; every filter moves only on it, except that sleep clears the current-fault counters on any clock
    logic [31:0] tick_cnt_reg;
    logic        tick;
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge core_clk) begin
        if (sys_rst || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // Hold-off after reset; drivers stay off until it expires
    logic [7:0] hold_cnt_reg;
    logic       hold_done;
    assign hold_done = (hold_cnt_reg == 8'(`HOLDOFF_TICKS));
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_cnt_reg <= '0;
        end else if (tick && !hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 8'h1;
        end
    end

    // Loaded configuration; software may rewrite it, a failed check reloads it
    count_t filt_reg;
    count_t check_reg;
    logic   check_due;
    logic   check_bad;
    logic   [7:0] chk_tick_reg;
    logic   wr_en_reg;
    logic   [7:0] wr_addr_reg;
    assign check_due = tick && (chk_tick_reg == 8'(`CHECK_TICKS - 1));
    assign check_bad = (check_reg != ~filt_reg);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chk_tick_reg <= '0;
        end else if (tick) begin
            chk_tick_reg <= check_due ? 8'h00 : chk_tick_reg + 8'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst || (check_due && check_bad)) begin
            filt_reg  <= `FILTER_RST;
            check_reg <= `CHECK_RST;
        end else if (wr_en_reg && wr_addr_reg == `OFS_FILTER) begin
            filt_reg <= hwdata[7:0];
        end else if (wr_en_reg && wr_addr_reg == `OFS_CHECK) begin
            check_reg <= hwdata[7:0];
        end
    end

    // Integrity counter; the lockout survives everything but reset
    logic [1:0] icnt_reg;
    logic       lock_reg;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            icnt_reg <= '0;
            lock_reg <= 1'b0;
        end else if (check_due && !lock_reg) begin
            if (check_bad) begin
                icnt_reg <= icnt_reg + 2'h1;
                lock_reg <= (icnt_reg == 2'(`INTEG_LIMIT - 1));
            end else if (icnt_reg != 2'h0) begin
                icnt_reg <= icnt_reg - 2'h1;
            end
        end
    end

    // Comparator self-test scheduler; runs forever, fail flag per comparator
    logic [7:0]            bist_tick_reg;
    logic                  bist_seen_ok_reg;
    logic [NUM_FAULTS-1:0] bist_fail_reg;
    logic                  bist_end;
    assign bist_end = tick && (bist_tick_reg == 8'(`BIST_TICKS - 1));
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bist_tick_reg    <= '0;
            selftest_sel     <= '0;
            bist_seen_ok_reg <= 1'b0;
            bist_fail_reg    <= '0;
        end else if (tick) begin
            bist_tick_reg    <= bist_end ? 8'h00 : bist_tick_reg + 8'h1;
            bist_seen_ok_reg <= bist_end ? 1'b0 : (bist_seen_ok_reg || !st_bad);
            if (bist_end) begin
                // Fault on every sample of the period declares it failed
                bist_fail_reg[selftest_sel] <= !bist_seen_ok_reg && st_bad;
                selftest_sel <= (selftest_sel == 4'(NUM_FAULTS - 1)) ? 4'h0 : selftest_sel + 4'h1;
            end
        end
    end

    // Driver requests built from qualified faults and overrides
    fault_vec_t flt_reg;
    logic [1:0] ovr_en_reg;
    logic       chg_off_req;
    logic       dsg_off_req;
    logic       hard_fault;
    logic       state_en;
    logic       chg_next;
    logic       dsg_next;
    logic       kill;
    assign hard_fault  = flt_reg[F_OW] | flt_reg[F_OTD] | flt_reg[F_UTD] |
                         flt_reg[F_OVERCURRENT_LEVEL_ONE] | flt_reg[F_OVERCURRENT_LEVEL_TWO] | flt_reg[F_SCD];
    assign chg_off_req = hard_fault | flt_reg[F_OV] | flt_reg[F_OTC] |
                         flt_reg[F_UTC] | !ovr_en_reg[0];
    assign dsg_off_req = hard_fault | flt_reg[F_UV] | !ovr_en_reg[1];
    assign state_en    = chg_off_req ^ dsg_off_req;
    assign kill        = lock_reg || (|bist_fail_reg) || !hold_done;
    assign chg_next    = !kill && (!chg_off_req || (state_en && dsg_cur));
    assign dsg_next    = !kill && (!dsg_off_req || (state_en && chg_cur));
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            charge_fet_drive    <= 1'b0;
            discharge_fet_drive <= 1'b0;
            upper_charge_out    <= 1'b0;
        end else begin
            charge_fet_drive    <= chg_next;
            discharge_fet_drive <= dsg_next;
            upper_charge_out    <= chg_next;
        end
    end

    // Per-fault add/subtract filter
    count_t flt_cnt [NUM_FAULTS];
    genvar g;
    generate
        for (g = 0; g < NUM_FAULTS; g++) begin : gen_filt
            // Current detection sleeps with the discharge driver; charge driver plays no part
            logic sleep;
            logic hit;
            assign sleep = (g == F_OVERCURRENT_LEVEL_ONE || g == F_OVERCURRENT_LEVEL_TWO || g == F_SCD) &&
                           !discharge_fet_drive && !flt_reg[g];
            assign hit   = flt_reg[g] ? !cond[g] : cond[g];
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    flt_reg[g] <= (g == F_OV);
                    flt_cnt[g] <= '0;
                end else if (sleep) begin
                    flt_cnt[g] <= '0;
                end else if (tick) begin
                    if (hit && flt_cnt[g] + 8'h1 >= filt_reg) begin
                        flt_reg[g] <= !flt_reg[g];
                        flt_cnt[g] <= '0;
                    end else if (hit) begin
                        flt_cnt[g] <= flt_cnt[g] + 8'h1;
                    end else if (flt_cnt[g] != 8'h0) begin
                        flt_cnt[g] <= flt_cnt[g] - 8'h1;
                    end
                end
            end
        end
    endgenerate

    // Override filters with hysteresis; start disabled at zero count
    count_t ovr_cnt [2];
    generate
        for (g = 0; g < 2; g++) begin : gen_ovr
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    ovr_cnt[g]    <= '0;
                    ovr_en_reg[g] <= 1'b0;
                end else if (tick) begin
                    if (ovr_raw[g] && ovr_cnt[g] != 8'(`OVR_FULL)) begin
                        ovr_cnt[g] <= ovr_cnt[g] + 8'h1;
                    end else if (!ovr_raw[g] && ovr_cnt[g] != 8'h0) begin
                        ovr_cnt[g] <= ovr_cnt[g] - 8'h1;
                    end
                    if (ovr_cnt[g] > 8'(`OVR_FULL * `OVR_ON_PCT / 100)) begin
                        ovr_en_reg[g] <= 1'b1;
                    end else if (ovr_cnt[g] < 8'(`OVR_FULL * `OVR_OFF_PCT / 100)) begin
                        ovr_en_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // AHB-Lite slave: zero wait states, always OKAY, read data loaded in address phase
    logic [31:0] status;
    logic        addr_ok;
    assign addr_ok = hsel && hready && htrans[1];
    assign status  = {6'h00, ovr_en_reg, 1'b0, state_en, icnt_reg, |bist_fail_reg,
                      lock_reg, discharge_fet_drive, charge_fet_drive, 6'h00, flt_reg};
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= '0;
            hrdata      <= '0;
        end else begin
            wr_en_reg   <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
            if (addr_ok && !hwrite) begin
                unique case (haddr)
                    `OFS_FILTER: hrdata <= {24'h000000, filt_reg};
                    `OFS_CHECK:  hrdata <= {24'h000000, check_reg};
                    `OFS_STATUS: hrdata <= status;
                    default:     hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Checks
    sequence fail_check_s;
        check_due && check_bad && !lock_reg;
    endsequence
    chk_lock_on_third: assert property (@(posedge core_clk) disable iff (sys_rst)
        fail_check_s and icnt_reg == 2'h2 |=> lock_reg)
        else $error("third failed check did not lock");
    chk_lock_kills_drv: assert property (@(posedge core_clk) disable iff (sys_rst)
        lock_reg |=> !charge_fet_drive && !discharge_fet_drive)
        else $error("drivers on during lockout");
    chk_pass_decrement: assert property (@(posedge core_clk) disable iff (sys_rst)
        check_due && !check_bad && !lock_reg && icnt_reg != 2'h0 |=> icnt_reg == $past(icnt_reg) - 2'h1)
        else $error("passing check did not decrement");
    chk_upper_mirror: assert property (@(posedge core_clk) disable iff (sys_rst)
        upper_charge_out == charge_fet_drive)
        else $error("upper charge output differs");
    chk_hard_no_state: assert property (@(posedge core_clk) disable iff (sys_rst)
        hard_fault |-> !state_en ##1 (!discharge_fet_drive && !charge_fet_drive))
        else $error("hard fault left a driver on");
    chk_holdoff_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        !hold_done |=> !charge_fet_drive && !discharge_fet_drive)
        else $error("driver on during hold-off");
    chk_ocd_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
        !discharge_fet_drive && !flt_reg[F_SCD] |=> flt_cnt[F_SCD] == 8'h0)
        else $error("short detection ran with discharge off");
    chk_chg_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
        !kill && !chg_off_req |=> charge_fet_drive)
        else $error("charge driver off with no cause");
    chk_body_diode: assert property (@(posedge core_clk) disable iff (sys_rst)
        !kill && dsg_off_req && !chg_off_req && chg_cur |=> discharge_fet_drive)
        else $error("no body diode turn-on");
    chk_trigger_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(flt_reg[F_UV]) |-> flt_cnt[F_UV] == 8'h0)
        else $error("counter not cleared on trigger");
    // A self-test period with at least one good sample
    sequence bist_good_s;
        bist_end && (bist_seen_ok_reg || !st_bad);
    endsequence
    chk_bist_kills_drv: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|bist_fail_reg) |=> !charge_fet_drive && !discharge_fet_drive)
        else $error("drivers on with a failed comparator");
    chk_bist_recovers: assert property (@(posedge core_clk) disable iff (sys_rst)
        bist_good_s |=> !bist_fail_reg[$past(selftest_sel)])
        else $error("good self-test left comparator failed");
    chk_ovr_chg_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ovr_en_reg[0] && !(state_en && dsg_cur) |=> !charge_fet_drive)
        else $error("charge driver on with override disabled");
    chk_ovr_dsg_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ovr_en_reg[1] && !(state_en && chg_cur) |=> !discharge_fet_drive)
        else $error("discharge driver on with override disabled");
    chk_ovr_on_level: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick && ovr_cnt[0] > 8'(`OVR_FULL * `OVR_ON_PCT / 100) |=> ovr_en_reg[0])
        else $error("override not enabled above upper level");
    chk_ovr_off_level: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick && ovr_cnt[1] < 8'(`OVR_FULL * `OVR_OFF_PCT / 100) |=> !ovr_en_reg[1])
        else $error("override not disabled below lower level");
    chk_dsg_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
        !kill && !dsg_off_req |=> discharge_fet_drive)
        else $error("discharge driver off with no cause");
    chk_chg_body_diode: assert property (@(posedge core_clk) disable iff (sys_rst)
        !kill && chg_off_req && !dsg_off_req && dsg_cur |=> charge_fet_drive)
        else $error("no charge body diode turn-on");
    chk_count_down: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick && !cond[F_OTD] && !flt_reg[F_OTD] && flt_cnt[F_OTD] != 8'h0
        |=> flt_cnt[F_OTD] == $past(flt_cnt[F_OTD]) - 8'h1)
        else $error("sample counter did not count down");
    chk_count_trigger: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick && !flt_reg[F_OTD] && cond[F_OTD] && flt_cnt[F_OTD] + 8'h1 >= filt_reg |=> flt_reg[F_OTD])
        else $error("fault not triggered at target count");
endmodule : protector_fet_fault_control
`default_nettype wire

// file: core/fet_fault_consts.svh
`ifndef FET_FAULT_CONSTS_SVH
`define FET_FAULT_CONSTS_SVH
// Register byte offsets
`define OFS_FILTER     8'h00
`define OFS_CHECK      8'h04
`define OFS_STATUS     8'h08
// Status field positions
`define ST_CHG_BIT     16
`define ST_DSG_BIT     17
`define ST_LOCK_BIT    18
`define ST_BIST_BIT    19
`define ST_ICNT_LSB    20
`define ST_STATE_BIT   22
`define ST_OVR_LSB     24
// Reset values of the loaded configuration
`define FILTER_RST     8'h05
`define CHECK_RST      8'hFA
// Timing
`define CLK_PERIOD_NS  20
`define TICK_NS        100000
`define HOLDOFF_NS     5000000
`define HOLDOFF_TICKS  (`HOLDOFF_NS / `TICK_NS)
`define CHECK_TICKS    100
`define BIST_TICKS     16
`define OVR_FULL       100
`define OVR_ON_PCT     70
`define OVR_OFF_PCT    30
`define INTEG_LIMIT    3
`endif

// file: core/fet_fault_pkg.sv
package fet_fault_pkg;
    // Fault index order in the comparator vector
    typedef enum logic [3:0] {
        F_OV, F_UV, F_OW, F_OTC, F_OTD, F_UTC, F_UTD, F_OVERCURRENT_LEVEL_ONE, F_OVERCURRENT_LEVEL_TWO, F_SCD
    } fault_id_t;
    typedef logic [9:0] fault_vec_t;
    typedef logic [7:0] count_t;
endpackage : fet_fault_pkg

// file: tb/fet_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Upper stacked device and comparator test path, as seen from this block
module fet_partner (
    input  wire logic core_clk,
    input  wire logic chg_cmd,
    input  wire logic dsg_cmd,
    input  wire logic bad_cmd,
    output logic      charge_override_in,
    output logic      discharge_override_in,
    output logic      selftest_bad_in
);
    // Known levels before the first edge
    initial begin
        charge_override_in = 1'b0;
        discharge_override_in = 1'b0;
        selftest_bad_in = 1'b0;
    end
    // Levels move just after the edge and stay solid for many ticks
    always @(posedge core_clk) begin
        charge_override_in    <= chg_cmd;
        discharge_override_in <= dsg_cmd;
        selftest_bad_in       <= bad_cmd; // Stuck test path fails every comparator
    end
endmodule : fet_partner
`default_nettype wire

// file: tb/protector_fet_fault_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fet_fault_consts.svh"
module protector_fet_fault_control_tb;
    import fet_fault_pkg::*;
    localparam int TICK = 4;
    logic        core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, rd_note, drv_probe;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    fault_vec_t  fault_cond;
    logic        chg_state, dsg_state, bad_in, chg_ovr, dsg_ovr, chg_cmd, dsg_cmd, bad_cmd;
    logic [3:0]  sel;
    logic        chg_drv, dsg_drv, upper_out;
    wire logic   hready;
    logic [31:0] exp_q[$], mask_q[$];
    logic [1:0]  drv_q[$];
    int          error_cnt, total_checks, cyc;
    // Driver state per fault index while that fault alone is active: {charge, discharge}
    logic [1:0]  fault_exp [10] = '{2'b01, 2'b10, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00, 2'b00, 2'b00, 2'b00};
    int          bd_idx [3] = '{0, 1, 4};
    logic [1:0]  bd_st [3] = '{2'b01, 2'b10, 2'b01};
    logic [1:0]  bd_exp [3] = '{2'b11, 2'b11, 2'b00};

    assign hready = hreadyout;

    protector_fet_fault_control #(.TICK_CYCLES(TICK)) i_protector_fet_fault_control (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .fault_cond_in(fault_cond), .charge_state_in(chg_state),
        .discharge_state_in(dsg_state), .selftest_bad_in(bad_in), .charge_override_in(chg_ovr),
        .discharge_override_in(dsg_ovr), .selftest_sel(sel), .charge_fet_drive(chg_drv),
        .discharge_fet_drive(dsg_drv), .upper_charge_out(upper_out));

    fet_partner i_fet_partner (
        .core_clk(core_clk), .chg_cmd(chg_cmd), .dsg_cmd(dsg_cmd), .bad_cmd(bad_cmd),
        .charge_override_in(chg_ovr), .discharge_override_in(dsg_ovr), .selftest_bad_in(bad_in));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task compare_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_word

    task compare_drv(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t drivers got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_drv

    // One single AHB-Lite transfer; the master waits on hready in both phases
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic note,
             output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rd_note <= note & ~wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        rd_note <= 1'b0;
    endtask : bus

    task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        exp_q.push_back(e);
        mask_q.push_back(m);
        bus(1'b0, a, 32'h0, 1'b1, d);
    endtask : rd_chk

    task wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, 1'b0, d);
    endtask : wr

    task expect_drv(input logic [1:0] e);
        drv_q.push_back(e);
        @(posedge core_clk);
        drv_probe <= 1'b1;
        @(posedge core_clk);
        drv_probe <= 1'b0;
    endtask : expect_drv

    task ticks(input int n);
        repeat (n * TICK) @(posedge core_clk);
    endtask : ticks

    // Bounded wait for a driver state, then note it for the monitor
    task wait_drv(input logic [1:0] e, input int lim);
        int n;
        n = 0;
        while ({chg_drv, dsg_drv} !== e && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        expect_drv(e);
    endtask : wait_drv

    // Exactly n sampled ticks high, since the level lasts n whole tick periods
    task pulse(input int i, input int n);
        fault_cond[i] <= 1'b1;
        ticks(n);
        fault_cond[i] <= 1'b0;
    endtask : pulse

    // Poll until a failed check has reloaded the default check word
    task wait_reload();
        logic [31:0] d;
        int n;
        d = 32'h0;
        n = 0;
        while (d[7:0] !== `CHECK_RST && n < 400) begin
            bus(1'b0, `OFS_CHECK, 32'h0, 1'b0, d);
            n++;
        end
    endtask : wait_reload

    // Results are taken off the queues as they appear at the ports
    always @(posedge core_clk) begin
        compare_word({31'h0, upper_out}, {31'h0, chg_drv});
        if (rd_note && hreadyout === 1'b1) begin
            compare_word(hrdata & mask_q.pop_front(), exp_q.pop_front());
            compare_word({30'h0, hreadyout, hresp}, 32'h2);
        end
        if (drv_probe) compare_drv({chg_drv, dsg_drv}, drv_q.pop_front());
    end

    // Self-test select steps through every comparator, one whole period each
    logic [3:0]  sel_prev;
    logic        sel_seen;
    int          sel_gap;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sel_prev <= 4'h0;
            sel_seen <= 1'b0;
            sel_gap  <= 0;
        end else begin
            sel_gap <= (sel !== sel_prev) ? 1 : sel_gap + 1;
            if (sel !== sel_prev) begin
                compare_word({28'h0, sel}, {28'h0, (sel_prev == 4'h9) ? 4'h0 : sel_prev + 4'h1});
                if (sel_seen) compare_word(sel_gap, `BIST_TICKS * TICK);
                sel_prev <= sel;
                sel_seen <= 1'b1;
            end
        end
    end

    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        int start;
        int idx;
        {hsel, hwrite, rd_note, drv_probe, chg_state, dsg_state, chg_cmd, dsg_cmd, bad_cmd} = '0;
        {haddr, htrans, hwdata, fault_cond} = '0;
        hsize = 3'h2;
        sys_rst = 1'b1;
        {error_cnt, total_checks, cyc} = '0;
        void'($urandom(32'h8D1C321A));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        chg_cmd <= 1'b1;
        dsg_cmd <= 1'b1;
        rd_chk(`OFS_STATUS, 32'h1, 32'h1);
        rd_chk(`OFS_FILTER, `FILTER_RST, 32'hFF);
        rd_chk(`OFS_CHECK, `CHECK_RST, 32'hFF);
        rd_chk(8'h0C, 32'h0, 32'hFFFFFFFF);
        ticks(40);
        expect_drv(2'b00);
        wait_drv(2'b11, 800);
        $display("test reset done");
        // Every fault alone, in index order from a random start
        start = $urandom % 10;
        for (int i = 0; i < 10; i++) begin
            idx = (start + i) % 10;
            @(posedge core_clk);
            fault_cond[idx] <= 1'b1;
            wait_drv(fault_exp[idx], 100);
            rd_chk(`OFS_STATUS, 32'(fault_exp[idx] inside {2'b01, 2'b10}) << `ST_STATE_BIT,
                   32'h1 << `ST_STATE_BIT);
            @(posedge core_clk);
            fault_cond[idx] <= 1'b0;
            wait_drv(2'b11, 100);
        end
        $display("test fault table done");
        // Net four hits stay short of the target, net five reach it
        @(posedge core_clk);
        pulse(F_OTD, 3);
        ticks(1);
        pulse(F_OTD, 2);
        ticks(1);
        expect_drv(2'b11);
        ticks(10);
        pulse(F_OTD, 3);
        ticks(1);
        pulse(F_OTD, 3);
        wait_drv(2'b00, 40);
        wait_drv(2'b11, 100);
        $display("test filter done");
        // Current through the body diode of the off device
        for (int j = 0; j < 3; j++) begin
            @(posedge core_clk);
            fault_cond[bd_idx[j]] <= 1'b1;
            wait_drv(fault_exp[bd_idx[j]], 100);
            {chg_state, dsg_state} <= bd_st[j];
            ticks(3);
            expect_drv(bd_exp[j]);
            {chg_state, dsg_state} <= 2'b00;
            fault_cond[bd_idx[j]] <= 1'b0;
            ticks(8);
            wait_drv(2'b11, 100);
        end
        // Overcurrent must not qualify while discharge is off
        @(posedge core_clk);
        fault_cond[F_UV] <= 1'b1;
        wait_drv(2'b10, 100);
        fault_cond[F_OVERCURRENT_LEVEL_ONE] <= 1'b1;
        ticks(10);
        fault_cond[F_UV] <= 1'b0;
        wait_drv(2'b11, 100);
        wait_drv(2'b00, 100);
        fault_cond[F_OVERCURRENT_LEVEL_ONE] <= 1'b0;
        wait_drv(2'b11, 100);
        $display("test state detection done");
        for (int j = 0; j < 2; j++) begin
            @(posedge core_clk);
            chg_cmd <= (j == 1);
            dsg_cmd <= (j == 0);
            ticks(60);
            expect_drv(2'b11);
            wait_drv(j == 1 ? 2'b10 : 2'b01, 200);
            ticks(35);
            chg_cmd <= 1'b1;
            dsg_cmd <= 1'b1;
            ticks(60);
            expect_drv(j == 1 ? 2'b10 : 2'b01);
            wait_drv(2'b11, 200);
        end
        $display("test override done");
        bad_cmd <= 1'b1;
        wait_drv(2'b00, 1400);
        bad_cmd <= 1'b0;
        wait_drv(2'b11, 1400);
        $display("test self test done");
        wr(`OFS_CHECK, 32'h0);
        wait_reload();
        rd_chk(`OFS_STATUS, 32'h1 << `ST_ICNT_LSB, 32'h3 << `ST_ICNT_LSB);
        repeat (500) @(posedge core_clk);
        rd_chk(`OFS_STATUS, 32'h0, 32'h3 << `ST_ICNT_LSB);
        repeat (`INTEG_LIMIT) begin
            wr(`OFS_CHECK, 32'h0);
            wait_reload();
        end
        wait_drv(2'b00, 50);
        repeat (500) @(posedge core_clk);
        expect_drv(2'b00);
        sys_rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_drv(2'b11, 800);
        $display("test integrity done");
        complete_run();
    end
endmodule : protector_fet_fault_control_tb
`default_nettype wire
